// file: bench/awps_sink.sv
// Output stage model that records every strobed sample
`timescale 1ns/100ps
module awps_sink (
    // Clock and analog path
    input wire logic pclk,
    input wire logic [11:0] sample_out,
    input wire logic sample_strobe
);
    logic [11:0] cap[$];
    // A point only counts when strobed, mid-step values are ignored
    always_ff @(posedge pclk) begin
        if (sample_strobe) cap.push_back(sample_out);
    end
endmodule : awps_sink

// file: bench/tb.sv
// Self-checking bench for the waveform playback store
`timescale 1ns/100ps
module tb;
    import awps_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, sample_strobe;
    logic signed [SAMPLE_W-1:0] sample_out, scaled_out;
    logic [11:0] d[4];
    logic signed [SAMPLE_W-1:0] prev_s = '0;
    int fail_count = 0, num_checks = 0;
    // Clock, 8 ns period
    initial begin
        forever #4 pclk = ~pclk;
    end
    awps_core #(.NSLOT(8), .CH_DEPTH(256), .BK_DEPTH(512)) i_dut (.pclk(pclk),
        .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sample_out(sample_out),
        .sample_strobe(sample_strobe), .scaled_out(scaled_out));
    awps_sink i_sink (.pclk(pclk), .sample_out(sample_out),
        .sample_strobe(sample_strobe));
    // Next point expected after a given one, low bits carry the address
    function automatic logic [31:0] nxt(input logic [11:0] v);
        return {20'h0, d[(v[1:0] + 2'd1)]};
    endfunction : nxt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Issue a command, wait for done or err, check and clear the status
    task automatic cmd(input logic [3:0] op, input logic [31:0] arg, input logic err);
        apb(1'b1, A_ARG, arg);
        apb(1'b1, A_CMD, {17'h0, 7'h01, 4'h0, op});
        repeat (100) begin
            apb(1'b0, A_IST, 32'h0);
            if (rd[1:0] !== 2'b00) break;
        end
        chk({30'h0, rd[1:0]}, {30'h0, err, !err});
        chk({31'h0, irq}, {31'h0, err});
        apb(1'b1, A_IST, 32'hf);
        chk({31'h0, irq}, 32'h0);
    endtask : cmd
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end
    // Main sequence
    initial begin
        void'($urandom(53));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, A_INC, 32'h0);
        chk(rd, INC_RST);
        apb(1'b0, A_AMP, 32'h0);
        chk(rd, {16'h0, AMP_RST});
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, A_IMASK, 32'h2);
        cmd(OP_CREATE, 32'h3, 1'b1);
        cmd(OP_CREATE, 32'h4, 1'b0);
        apb(1'b0, A_BKTOP, 32'h0);
        chk(rd, 32'h4);
        for (int i = 0; i < 4; i++) begin
            d[i] = {10'($urandom_range(1023, 0)), 2'(i)};
            cmd(OP_EDIT, {16'(i), 4'h0, d[i]}, 1'b0);
        end
        cmd(OP_LOAD, 32'h0, 1'b0);
        // Edit of a loaded waveform must reach the channel copy too
        d[2] = {10'($urandom), 2'd2};
        cmd(OP_EDIT, {16'd2, 4'h0, d[2]}, 1'b0);
        d[3] = {10'($urandom), 2'd3};
        cmd(OP_LOCAL, {16'd3, 4'h0, d[3]}, 1'b0);
        cmd(OP_SAVE, 32'h0, 1'b0);
        cmd(OP_DEL_BK, 32'h0, 1'b1);
        cmd(OP_SELECT, 32'h0, 1'b0);
        apb(1'b1, A_INC, 32'h5000_0000);
        apb(1'b1, A_AMP, 32'h8000);
        apb(1'b1, A_CTRL, 32'h1);
        // Half gain halves every settled sample
        repeat (60) begin
            @(posedge pclk);
            if (sample_out == prev_s) chk(scaled_out, prev_s >>> 1);
            prev_s = sample_out;
        end
        cmd(OP_UNLOAD, 32'h0, 1'b1);
        apb(1'b1, A_SEQ0, 32'h2);
        apb(1'b1, A_CTRL, 32'h3);
        cmd(OP_UNLOAD, 32'h0, 1'b1);
        apb(1'b1, A_CTRL, 32'h0);
        chk({31'h0, i_sink.cap.size() > 16}, 32'h1);
        chk({20'h0, i_sink.cap[0]}, {20'h0, d[0]});
        for (int j = 0; j + 1 < i_sink.cap.size(); j++) begin
            chk({20'h0, i_sink.cap[j + 1]}, nxt(i_sink.cap[j]));
        end
        cmd(OP_UNLOAD, 32'h0, 1'b0);
        cmd(OP_DEL_BK, 32'h0, 1'b0);
        apb(1'b0, A_BKTOP, 32'h0);
        chk(rd, 32'h0);
        end_sim();
    end
endmodule : tb

// file: rtl/awps_core.sv
// Arbitrary waveform playback with backup store and channel memory
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
module awps_core #(
    parameter int NSLOT = awps_pkg::SLOTS,
    parameter int CH_DEPTH = awps_pkg::CH_POINTS,
    parameter int BK_DEPTH = awps_pkg::BK_POINTS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Analog path
    output logic signed [awps_pkg::SAMPLE_W-1:0] sample_out,
    output logic sample_strobe,
    output logic signed [awps_pkg::SAMPLE_W-1:0] scaled_out
);
    import awps_pkg::*;

    localparam int SW = $clog2(NSLOT);
    localparam int CW = $clog2(CH_DEPTH);
    localparam int BW = $clog2(BK_DEPTH);
    localparam int LW = CW + 1;

    // Storage arrays, written only through enables
    logic [SAMPLE_W-1:0] bk_mem [BK_DEPTH];
    logic [SAMPLE_W-1:0] ch_mem [CH_DEPTH];
    logic [BW-1:0] bk_base [NSLOT];
    logic [LW-1:0] bk_len [NSLOT];
    logic [CW-1:0] ch_base [NSLOT];

    // Register state
    logic [1:0] ctrl, next_ctrl;
    logic [31:0] inc, next_inc;
    logic [15:0] amp, next_amp;
    logic [31:0] arg, next_arg;
    logic [127:0] seq_mask, next_seq_mask;
    logic [EV_N-1:0] ist, next_ist;
    logic [EV_N-1:0] imask, next_imask;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq;

    // Directory and copy engine state
    logic [NSLOT-1:0] bk_valid, next_bk_valid;
    logic [NSLOT-1:0] ch_loaded, next_ch_loaded;
    logic [BW:0] bk_top, next_bk_top;
    logic [LW-1:0] ch_top, next_ch_top;
    awps_st_t st, next_st;
    logic [BW-1:0] cp_src, next_cp_src;
    logic [BW-1:0] cp_dst, next_cp_dst;
    logic [LW-1:0] cp_cnt, next_cp_cnt;
    logic cp_up, next_cp_up;

    // Playback state
    logic [31:0] acc, next_acc;
    logic [SW-1:0] cur, next_cur;
    logic [CW-1:0] addr, next_addr;
    logic cur_ok, next_cur_ok;
    logic seq_good_q, next_seq_good_q;
    logic signed [SAMPLE_W-1:0] next_sample, next_scaled;
    logic next_strobe;

    // Strobes between groups
    logic commit, acc_ph, wr_cmd;
    logic ev_done, ev_err, ev_wrap, ev_bad;
    logic bk_we, ch_we, dir_we, chb_we, sel_go;
    logic [BW-1:0] bk_wa;
    logic [CW-1:0] ch_wa;
    logic [SAMPLE_W-1:0] bk_wd, ch_wd;
    logic [BW-1:0] dir_base;
    logic [LW-1:0] dir_len;
    logic [CW-1:0] chb_val;
    logic [SW-1:0] cs;
    logic sl_ok;
    awps_op_t op;
    logic [LW-1:0] len_arg, cs_len;
    logic [CW-1:0] pa;
    logic playing, tick;
    logic [31:0] inc_c;
    logic [LW-1:0] cur_last;
    logic seq_good;
    logic [NSLOT-1:0] seq_ok_v;

    // Per-slot sequence readiness: masked slots must sit in channel memory
    genvar gi;
    generate
        for (gi = 0; gi < NSLOT; gi++) begin : g_seq
            assign seq_ok_v[gi] = ~seq_mask[gi] | ch_loaded[gi];
        end
    endgenerate
    assign seq_good = &seq_ok_v;

    // Next masked slot after c, wrapping round
    function automatic logic [SW-1:0] seq_next(input logic [SW-1:0] c,
                                               input logic [NSLOT-1:0] m);
        logic [SW-1:0] r;
        logic f;
        int k;
        r = c;
        f = 1'b0;
        for (int i = 1; i <= NSLOT; i++) begin
            k = (int'(c) + i) % NSLOT;
            if (!f && m[k]) begin
                r = SW'(k);
                f = 1'b1;
            end
        end
        return r;
    endfunction : seq_next

    // Clamp the arb step so the arb clock stays within its range
    assign inc_c = (inc < INC_MIN) ? INC_MIN :
                   (inc > INC_MAX) ? INC_MAX : inc;
    assign playing = ctrl[0] & cur_ok & (~ctrl[1] | seq_good);
    assign cur_last = bk_len[cur] - LW'(1);

    // APB phase decode; answer comes one cycle into the access phase
    assign acc_ph = psel & penable & ~pready;
    assign commit = psel & penable & pready & pwrite;
    assign wr_cmd = commit & (paddr == A_CMD);

    // Register file and bus answer
    always_comb begin
        next_ctrl = ctrl;
        next_inc = inc;
        next_amp = amp;
        next_arg = arg;
        next_seq_mask = seq_mask;
        next_imask = imask;
        next_ist = ist;
        next_pready = acc_ph;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (commit) begin
            case (paddr)
                A_CTRL: next_ctrl = pwdata[1:0];
                A_INC: next_inc = pwdata;
                A_AMP: next_amp = pwdata[15:0];
                A_ARG: next_arg = pwdata;
                A_IST: next_ist = ist & ~pwdata[EV_N-1:0];
                A_IMASK: next_imask = pwdata[EV_N-1:0];
                A_SEQ0: next_seq_mask[31:0] = pwdata;
                A_SEQ0 + 8'h04: next_seq_mask[63:32] = pwdata;
                A_SEQ0 + 8'h08: next_seq_mask[95:64] = pwdata;
                A_SEQ0 + 8'h0c: next_seq_mask[127:96] = pwdata;
                default: next_ctrl = ctrl;
            endcase
        end
        // Set wins over a write-one clear in the same cycle
        next_ist = next_ist | {ev_bad, ev_wrap, ev_err, ev_done};
        next_irq = |(next_ist & next_imask);
        if (acc_ph) begin
            next_prdata = 32'h0;
            case (paddr)
                A_CTRL: next_prdata = {30'h0, ctrl};
                A_INC: next_prdata = inc;
                A_AMP: next_prdata = {16'h0, amp};
                A_ARG: next_prdata = arg;
                A_CMD: next_prdata = {30'h0, st};
                A_STAT: next_prdata = {16'(addr), 1'b0, 7'(cur), 5'h0,
                                       ~seq_good, playing, st != ST_IDLE};
                A_IST: next_prdata = {28'h0, ist};
                A_IMASK: next_prdata = {28'h0, imask};
                A_BKTOP: next_prdata = 32'(bk_top);
                A_CHTOP: next_prdata = 32'(ch_top);
                A_SEQ0: next_prdata = seq_mask[31:0];
                A_SEQ0 + 8'h04: next_prdata = seq_mask[63:32];
                A_SEQ0 + 8'h08: next_prdata = seq_mask[95:64];
                A_SEQ0 + 8'h0c: next_prdata = seq_mask[127:96];
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 2'h0;
            inc <= INC_RST;
            amp <= AMP_RST;
            arg <= 32'h0;
            seq_mask <= 128'h0;
            ist <= 4'h0;
            imask <= 4'h0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            ctrl <= next_ctrl;
            inc <= next_inc;
            amp <= next_amp;
            arg <= next_arg;
            seq_mask <= next_seq_mask;
            ist <= next_ist;
            imask <= next_imask;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end

    // Command fields; out-of-range slots fold to zero and are refused
    assign op = awps_op_t'(pwdata[3:0]);
    assign sl_ok = 32'(pwdata[14:8]) < NSLOT;
    assign cs = sl_ok ? SW'(pwdata[14:8]) : '0;
    assign cs_len = bk_len[cs];
    assign len_arg = arg[LW-1:0];
    assign pa = arg[16 +: CW];

    // Directory commands and the word-per-cycle copy engine
    always_comb begin
        next_bk_valid = bk_valid;
        next_ch_loaded = ch_loaded;
        next_bk_top = bk_top;
        next_ch_top = ch_top;
        next_st = st;
        next_cp_src = cp_src;
        next_cp_dst = cp_dst;
        next_cp_cnt = cp_cnt;
        next_cp_up = cp_up;
        ev_done = 1'b0;
        ev_err = 1'b0;
        bk_we = 1'b0;
        ch_we = 1'b0;
        dir_we = 1'b0;
        chb_we = 1'b0;
        sel_go = 1'b0;
        bk_wa = cp_dst;
        bk_wd = ch_mem[CW'(cp_src)];
        ch_wa = CW'(cp_dst);
        ch_wd = bk_mem[cp_src];
        dir_base = BW'(bk_top);
        dir_len = len_arg;
        chb_val = CW'(ch_top);
        case (st)
            ST_COPY: begin
                bk_we = cp_up;
                ch_we = ~cp_up;
                next_cp_src = cp_src + BW'(1);
                next_cp_dst = cp_dst + BW'(1);
                next_cp_cnt = cp_cnt - LW'(1);
                if (cp_cnt == LW'(1)) begin
                    next_st = ST_DONE;
                end
            end
            ST_DONE: begin
                ev_done = 1'b1;
                next_st = ST_IDLE;
            end
            default: next_st = ST_IDLE;
        endcase
        // Busy engine refuses every command
        if (wr_cmd && st != ST_IDLE) begin
            ev_err = 1'b1;
        end else if (wr_cmd) begin
            ev_err = 1'b1;
            case (op)
                OP_CREATE: begin
                    if (sl_ok && !bk_valid[cs] && len_arg >= LW'(MIN_LEN)
                        && 32'(len_arg) <= CH_DEPTH
                        && 32'(bk_top) + 32'(len_arg) <= BK_DEPTH) begin
                        ev_err = 1'b0;
                        ev_done = 1'b1;
                        dir_we = 1'b1;
                        next_bk_valid[cs] = 1'b1;
                        next_bk_top = bk_top + (BW + 1)'(len_arg);
                    end
                end
                OP_DEL_BK: begin
                    if (sl_ok && bk_valid[cs] && !ch_loaded[cs]) begin
                        ev_err = 1'b0;
                        ev_done = 1'b1;
                        next_bk_valid[cs] = 1'b0;
                        if (next_bk_valid == '0) begin
                            next_bk_top = '0;
                        end
                    end
                end
                OP_LOAD: begin
                    if (sl_ok && bk_valid[cs] && !ch_loaded[cs]
                        && 32'(ch_top) + 32'(cs_len) <= CH_DEPTH) begin
                        ev_err = 1'b0;
                        chb_we = 1'b1;
                        next_ch_loaded[cs] = 1'b1;
                        next_ch_top = ch_top + cs_len;
                        next_cp_src = bk_base[cs];
                        next_cp_dst = BW'(ch_top);
                        next_cp_cnt = cs_len;
                        next_cp_up = 1'b0;
                        next_st = ST_COPY;
                    end
                end
                OP_UNLOAD: begin
                    if (sl_ok && ch_loaded[cs]
                        && !(ctrl[0] && ctrl[1])
                        && !(playing && cs == cur)) begin
                        ev_err = 1'b0;
                        ev_done = 1'b1;
                        next_ch_loaded[cs] = 1'b0;
                        if (next_ch_loaded == '0) begin
                            next_ch_top = '0;
                        end
                    end
                end
                OP_SELECT: begin
                    if (sl_ok && ch_loaded[cs]) begin
                        ev_err = 1'b0;
                        ev_done = 1'b1;
                        sel_go = 1'b1;
                    end
                end
                OP_EDIT: begin
                    if (sl_ok && bk_valid[cs] && {1'b0, pa} < cs_len) begin
                        ev_err = 1'b0;
                        bk_we = 1'b1;
                        bk_wa = bk_base[cs] + BW'(pa);
                        bk_wd = arg[SAMPLE_W-1:0];
                        if (ch_loaded[cs]) begin
                            next_cp_src = bk_base[cs] + BW'(pa);
                            next_cp_dst = BW'(CW'(ch_base[cs] + pa));
                            next_cp_cnt = LW'(1);
                            next_cp_up = 1'b0;
                            next_st = ST_COPY;
                        end else begin
                            ev_done = 1'b1;
                        end
                    end
                end
                OP_LOCAL: begin
                    if (sl_ok && ch_loaded[cs] && {1'b0, pa} < cs_len) begin
                        ev_err = 1'b0;
                        ev_done = 1'b1;
                        ch_we = 1'b1;
                        ch_wa = CW'(ch_base[cs] + pa);
                        ch_wd = arg[SAMPLE_W-1:0];
                    end
                end
                OP_SAVE: begin
                    if (sl_ok && ch_loaded[cs]) begin
                        ev_err = 1'b0;
                        next_cp_src = BW'(ch_base[cs]);
                        next_cp_dst = bk_base[cs];
                        next_cp_cnt = cs_len;
                        next_cp_up = 1'b1;
                        next_st = ST_COPY;
                    end
                end
                default: ev_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bk_valid <= '0;
            ch_loaded <= '0;
            bk_top <= '0;
            ch_top <= '0;
            st <= ST_IDLE;
            cp_src <= '0;
            cp_dst <= '0;
            cp_cnt <= '0;
            cp_up <= 1'b0;
        end else if (clk_en) begin
            bk_valid <= next_bk_valid;
            ch_loaded <= next_ch_loaded;
            bk_top <= next_bk_top;
            ch_top <= next_ch_top;
            st <= next_st;
            cp_src <= next_cp_src;
            cp_dst <= next_cp_dst;
            cp_cnt <= next_cp_cnt;
            cp_up <= next_cp_up;
        end
    end

    // Memories carry no reset; contents are qualified by the directory
    always_ff @(posedge pclk) begin
        if (clk_en) begin
            if (bk_we) begin
                bk_mem[bk_wa] <= bk_wd;
            end
            if (ch_we) begin
                ch_mem[ch_wa] <= ch_wd;
            end
            if (dir_we) begin
                bk_base[cs] <= dir_base;
                bk_len[cs] <= dir_len;
            end
            if (chb_we) begin
                ch_base[cs] <= chb_val;
            end
        end
    end

    // Playback: phase accumulator carry is the arb clock tick
    always_comb begin
        next_acc = acc;
        tick = 1'b0;
        next_cur = cur;
        next_addr = addr;
        next_cur_ok = cur_ok & ch_loaded[cur];
        next_sample = sample_out;
        next_strobe = 1'b0;
        next_seq_good_q = seq_good;
        ev_wrap = 1'b0;
        ev_bad = seq_good_q & ~seq_good & ctrl[1];
        if (playing) begin
            {tick, next_acc} = {1'b0, acc} + {1'b0, inc_c};
        end
        if (sel_go) begin
            next_cur = cs;
            next_addr = '0;
            next_cur_ok = 1'b1;
        end else if (tick) begin
            next_strobe = 1'b1;
            next_sample = ch_mem[CW'(ch_base[cur] + addr)];
            if ({1'b0, addr} == cur_last) begin
                next_addr = '0;
                ev_wrap = 1'b1;
                if (ctrl[1]) begin
                    next_cur = seq_next(cur, seq_mask[NSLOT-1:0] & ch_loaded);
                end
            end else begin
                next_addr = addr + CW'(1);
            end
        end
        // Linear gain: amp of all ones is full scale
        next_scaled = SAMPLE_W'((29'(sample_out) * $signed({13'h0, amp})) >>> 16);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 32'h0;
            cur <= '0;
            addr <= '0;
            cur_ok <= 1'b0;
            seq_good_q <= 1'b1;
            sample_out <= '0;
            sample_strobe <= 1'b0;
            scaled_out <= '0;
        end else if (clk_en) begin
            acc <= next_acc;
            cur <= next_cur;
            addr <= next_addr;
            cur_ok <= next_cur_ok;
            seq_good_q <= next_seq_good_q;
            sample_out <= next_sample;
            sample_strobe <= next_strobe;
            scaled_out <= next_scaled;
        end
    end

    // Checks
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn || !clk_en);

    addr_wrap_a: assert property (clk_en && tick && !sel_go && {1'b0, addr} == cur_last
        |=> addr == '0 && ist[EV_WRAP])
        else $error("address did not wrap to zero");
    addr_step_a: assert property (clk_en && tick && !sel_go && {1'b0, addr} != cur_last
        |=> addr == $past(addr) + CW'(1) && sample_strobe)
        else $error("address did not step on tick");
    len_range_a: assert property (clk_en && wr_cmd && op == OP_CREATE
        && len_arg < LW'(MIN_LEN) |=> ist[EV_ERR] && $stable(bk_top))
        else $error("short waveform accepted");
    chan_fit_a: assert property (32'(ch_top) <= CH_DEPTH)
        else $error("channel memory overfilled");
    bk_guard_a: assert property (clk_en && wr_cmd && st == ST_IDLE && op == OP_DEL_BK
        && sl_ok && ch_loaded[cs] |=> bk_valid[$past(cs)])
        else $error("loaded waveform removed from backup");
    seq_guard_a: assert property (clk_en && wr_cmd && op == OP_UNLOAD
        && ctrl == 2'h3 |=> ch_loaded == $past(ch_loaded))
        else $error("removal during sequence");
    play_guard_a: assert property (clk_en && wr_cmd && op == OP_UNLOAD && playing
        && cs == cur |=> ch_loaded[$past(cs)])
        else $error("playing waveform removed");
    edit_order_a: assert property (clk_en && wr_cmd && st == ST_IDLE && op == OP_EDIT
        && bk_we && ch_loaded[cs] |=> st == ST_COPY ##1 st == ST_DONE)
        else $error("edit not copied to channel");
    inc_range_a: assert property (playing |-> inc_c >= INC_MIN && inc_c <= INC_MAX)
        else $error("arb step out of range");
endmodule : awps_core

// file: rtl/awps_pkg.sv
// Constants, types and encodings for the arbitrary waveform playback store
// What this block does
// - Step RAM address once per arb tick
// - Repeat rate is arb rate over length
// - Waveform length from 4 to 65536
// - Addresses start at zero, end length-1
// - Samples signed twelve bit, -2048 to 2047
// - Arb clock programmable 0.1 Hz to 40 MHz
// - Output amplitude scales linearly with sample span
// - Backup store holds 100 waveforms, 256 kByte
// - Channel memory holds at most 65536 points
// - Edits hit backup first, then channel copies
// - Local edits reach backup only on save
// - No removal of the playing waveform
// - Backup removal needs channel removal first
// - No channel removals while sequence plays
// - Idle sequence may lose waveforms, then invalid
// - Illegal operations rejected with error flag
package awps_pkg;
    // Sizes
    localparam int SLOTS = 100;
    localparam int CH_POINTS = 65536;
    localparam int BK_POINTS = 131072; // 256 kByte of 16-bit words
    localparam int MIN_LEN = 4;
    localparam int SAMPLE_W = 12;
    localparam int AMP_W = 16;
    // Arb clock limits, rates in their own units
    localparam longint CLK_HZ = 125_000_000;
    localparam longint ARB_MIN_DHZ = 1; // 0.1 Hz in tenths
    localparam longint ARB_MAX_HZ = 40_000_000;
    localparam longint ACC_ONE = 64'h1_0000_0000;
    localparam logic [31:0] INC_MIN =
        32'((ACC_ONE * ARB_MIN_DHZ + CLK_HZ * 10 - 1) / (CLK_HZ * 10));
    localparam logic [31:0] INC_MAX = 32'(ACC_ONE * ARB_MAX_HZ / CLK_HZ);
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_INC = 8'h04;
    localparam logic [7:0] A_AMP = 8'h08;
    localparam logic [7:0] A_ARG = 8'h0c;
    localparam logic [7:0] A_CMD = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;
    localparam logic [7:0] A_IST = 8'h18;
    localparam logic [7:0] A_IMASK = 8'h1c;
    localparam logic [7:0] A_BKTOP = 8'h20;
    localparam logic [7:0] A_CHTOP = 8'h24;
    localparam logic [7:0] A_SEQ0 = 8'h28; // Four words up to 8'h34
    // Reset values
    localparam logic [31:0] INC_RST = 32'h0000_1000;
    localparam logic [15:0] AMP_RST = 16'hffff;
    // Event bits of the status and mask registers
    localparam int EV_DONE = 0;
    localparam int EV_ERR = 1;
    localparam int EV_WRAP = 2;
    localparam int EV_SEQBAD = 3;
    localparam int EV_N = 4;
    // Commands
    typedef enum logic [3:0] {
        OP_CREATE = 4'h0, OP_DEL_BK = 4'h1, OP_LOAD = 4'h2,
        OP_UNLOAD = 4'h3, OP_SELECT = 4'h4, OP_EDIT = 4'h5,
        OP_LOCAL = 4'h6, OP_SAVE = 4'h7
    } awps_op_t;
    // Copy engine states, Gray along idle-copy-done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_COPY = 2'b01, ST_DONE = 2'b11
    } awps_st_t;
endpackage : awps_pkg
